// file: logic/an_regs_pkg.sv
// Package: register map, field layout and carrier types of the partner page register bank
package an_regs_pkg;
   // Printed offsets are indexes; byte address is four times the index
   localparam logic [3:0] idx_partner_ability = 4'h5;
   localparam logic [3:0] idx_negotiation_expansion = 4'h6;
   localparam logic [3:0] idx_outgoing_page = 4'h7;
   localparam logic [7:0] addr_partner_ability = {2'h0, idx_partner_ability, 2'h0};
   localparam logic [7:0] addr_negotiation_expansion = {2'h0, idx_negotiation_expansion, 2'h0};
   localparam logic [7:0] addr_outgoing_page = {2'h0, idx_outgoing_page, 2'h0};
   localparam logic [7:0] addr_engine_ctrl = 8'h40;
   localparam logic [7:0] addr_engine_status = 8'h44;

   // Field positions
   localparam int pos_more_pages = 15;
   localparam int pos_ack = 14;
   localparam int pos_fault = 13;
   localparam int pos_message = 13;
   localparam int pos_comply = 12;
   localparam int pos_toggle = 11;
   localparam int pos_loc_known = 6;
   localparam int pos_store_sel = 5;
   localparam int pos_pd_fault = 4;
   localparam int pos_partner_multi = 3;
   localparam int pos_local_multi = 2;
   localparam int pos_page_rx = 1;
   localparam int pos_partner_neg = 0;
   localparam int code_width = 11;

   // Masks and reset values
   localparam logic [15:0] partner_ability_mask = 16'hEFFF;
   localparam logic [15:0] partner_ability_reset = 16'h0000;
   localparam logic [15:0] outgoing_page_reset = 16'h2001;
   localparam logic [15:0] outgoing_page_wmask = 16'hB7FF;
   localparam logic [31:0] bad_addr_data = 32'h0000_0000;
   localparam logic [1:0] resp_okay = 2'h0;
   localparam logic [1:0] resp_slverr = 2'h2;

   // Events and levels from the negotiation state machine
   typedef struct packed {
      logic base_page_valid;
      logic [15:0] base_page;
      logic next_page_valid;
      logic [15:0] next_page;
      logic page_received;
      logic partner_negotiates;
      logic partner_multi_page;
      logic parallel_detect_fault;
      logic local_ack;
      logic word_sent;
   } engine_in_type;

   typedef enum logic [1:0] {
      rd_idle = 2'b00,
      rd_resp = 2'b01
   } rd_state_type;

   typedef enum logic [1:0] {
      wr_idle = 2'b00,
      wr_resp = 2'b01
   } wr_state_type;

   typedef struct packed {
      logic [15:0] partner_ability;
      logic pd_fault;
      logic partner_multi;
      logic page_rx;
      logic partner_neg;
      logic [15:0] outgoing_page;
      logic last_toggle;
      logic engine_enable;
      rd_state_type rd_state;
      logic [31:0] rdata;
      logic [1:0] rresp;
      wr_state_type wr_state;
      logic aw_held;
      logic [7:0] aw_addr;
      logic w_held;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic [1:0] bresp;
      logic [15:0] page_out;
      logic engine_enable_out;
   } state_type;
endpackage

// file: logic/autoneg_partner_page_regs.sv
// Partner ability, expansion status and next page transmit registers behind an AXI4-Lite slave
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module autoneg_partner_page_regs
   import an_regs_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address and data
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Negotiation state machine, same clock
   input wire engine_in_type engine_in,
   // Page handed to the transmit side and engine enable
   output logic [15:0] page_out,
   output logic engine_enable
);

   state_type state_reg;
   state_type state_next;

   logic aw_take;
   logic w_take;
   logic ar_take;
   logic [15:0] expansion_view;
   logic [15:0] outgoing_view;
   logic [31:0] read_word;
   logic read_ok;
   logic [15:0] wbits;
   logic [15:0] wmask16;

   // ----------------------------------------------------------------
   // Register views
   // ----------------------------------------------------------------
   always_comb begin
      expansion_view = 16'h0000;
      expansion_view[pos_loc_known] = 1'b1;
      expansion_view[pos_store_sel] = 1'b1;
      expansion_view[pos_pd_fault] = state_reg.pd_fault;
      expansion_view[pos_partner_multi] = state_reg.partner_multi;
      expansion_view[pos_local_multi] = 1'b1;
      expansion_view[pos_page_rx] = state_reg.page_rx;
      expansion_view[pos_partner_neg] = state_reg.partner_neg;
      outgoing_view = state_reg.outgoing_page;
      outgoing_view[pos_ack] = engine_in.local_ack;
      outgoing_view[pos_toggle] = ~state_reg.last_toggle;
   end

   always_comb begin
      read_ok = 1'b1;
      case (s_axi_araddr)
         addr_partner_ability: read_word = {16'h0000, state_reg.partner_ability & partner_ability_mask};
         addr_negotiation_expansion: read_word = {16'h0000, expansion_view};
         addr_outgoing_page: read_word = {16'h0000, outgoing_view};
         addr_engine_ctrl: read_word = {31'h0000_0000, state_reg.engine_enable};
         addr_engine_status: read_word = {31'h0000_0000, state_reg.last_toggle};
         default: begin
            read_word = bad_addr_data;
            read_ok = 1'b0;
         end
      endcase
   end

   assign aw_take = s_axi_awvalid & ~state_reg.aw_held & (state_reg.wr_state == wr_idle);
   assign w_take = s_axi_wvalid & ~state_reg.w_held & (state_reg.wr_state == wr_idle);
   assign ar_take = s_axi_arvalid & (state_reg.rd_state == rd_idle);
   assign wbits = state_reg.w_data[15:0];
   assign wmask16 = {{8{state_reg.w_strb[1]}}, {8{state_reg.w_strb[0]}}};

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      state_next = state_reg;

      // Engine updates
      if (engine_in.base_page_valid) begin
         state_next.partner_ability = engine_in.base_page & partner_ability_mask;
      end else if (engine_in.next_page_valid && state_reg.partner_multi) begin
         // Later pages only overwrite when both ends do next pages
         state_next.partner_ability = engine_in.next_page & partner_ability_mask;
      end
      state_next.pd_fault = engine_in.parallel_detect_fault;
      state_next.partner_multi = engine_in.partner_multi_page;
      state_next.partner_neg = engine_in.partner_negotiates;
      if (engine_in.word_sent) begin
         // The word just sent carried the inverse of the remembered toggle
         state_next.last_toggle = ~state_reg.last_toggle;
      end

      // Read channel; clear before set so a new word is never lost
      if (ar_take) begin
         state_next.rdata = read_word;
         state_next.rresp = read_ok ? resp_okay : resp_slverr;
         state_next.rd_state = rd_resp;
         if (s_axi_araddr == addr_negotiation_expansion) begin
            state_next.page_rx = 1'b0;
         end
      end else if (state_reg.rd_state == rd_resp && s_axi_rready) begin
         state_next.rd_state = rd_idle;
      end
      if (engine_in.page_received) begin
         state_next.page_rx = 1'b1;
      end

      // Write channel: address and data taken in either order
      if (aw_take) begin
         state_next.aw_held = 1'b1;
         state_next.aw_addr = s_axi_awaddr;
      end
      if (w_take) begin
         state_next.w_held = 1'b1;
         state_next.w_data = s_axi_wdata;
         state_next.w_strb = s_axi_wstrb;
      end
      if (state_reg.wr_state == wr_idle && state_reg.aw_held && state_reg.w_held) begin
         state_next.aw_held = 1'b0;
         state_next.w_held = 1'b0;
         state_next.wr_state = wr_resp;
         state_next.bresp = resp_okay;
         case (state_reg.aw_addr)
            addr_outgoing_page: begin
               // Only writable fields move; acknowledge and toggle stay put
               state_next.outgoing_page = (state_reg.outgoing_page & ~(outgoing_page_wmask & wmask16))
                  | (wbits & outgoing_page_wmask & wmask16);
            end
            addr_engine_ctrl: begin
               if (state_reg.w_strb[0]) begin
                  state_next.engine_enable = state_reg.w_data[0];
               end
            end
            addr_partner_ability, addr_negotiation_expansion, addr_engine_status: begin
               state_next.bresp = resp_okay;
            end
            default: state_next.bresp = resp_slverr;
         endcase
      end else if (state_reg.wr_state == wr_resp && s_axi_bready) begin
         state_next.wr_state = wr_idle;
      end

      state_next.page_out = outgoing_view;
      state_next.engine_enable_out = state_next.engine_enable;
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= '0;
         state_reg.partner_ability <= partner_ability_reset;
         state_reg.outgoing_page <= outgoing_page_reset;
         state_reg.rd_state <= rd_idle;
         state_reg.wr_state <= wr_idle;
         state_reg.page_out <= outgoing_page_reset ^ 16'h0800;
      end else begin
         state_reg <= state_next;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign s_axi_awready = ~state_reg.aw_held & (state_reg.wr_state == wr_idle);
   assign s_axi_wready = ~state_reg.w_held & (state_reg.wr_state == wr_idle);
   assign s_axi_bvalid = (state_reg.wr_state == wr_resp);
   assign s_axi_bresp = state_reg.bresp;
   assign s_axi_arready = (state_reg.rd_state == rd_idle);
   assign s_axi_rvalid = (state_reg.rd_state == rd_resp);
   assign s_axi_rdata = state_reg.rdata;
   assign s_axi_rresp = state_reg.rresp;
   assign page_out = state_reg.page_out;
   assign engine_enable = state_reg.engine_enable_out;

endmodule
`default_nettype wire

// file: sim/an_regs_monitor.sv
// Checker on the register bank ports: bus answers and the outgoing page view
`timescale 1ns/10ps
`default_nettype none
module an_regs_monitor
   import an_regs_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Bus
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Engine side
   input wire engine_in_type engine_in,
   input wire logic [15:0] page_out
);
   logic [7:0] ar_last_reg;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Remembers which register the pending answer belongs to
   always_ff @(posedge aclk) begin
      if (s_axi_arvalid && s_axi_arready) ar_last_reg <= s_axi_araddr;
   end
   chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer missing");
   chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data not held");
   chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:3] s_axi_bvalid) else $error("write answer missing");
   chk_exp_fixed: assert property (s_axi_rvalid && ar_last_reg == addr_negotiation_expansion
      |-> {s_axi_rdata[15:5], s_axi_rdata[2]} == 12'h007) else $error("expansion fixed bits wrong");
   chk_reserved_bit: assert property (s_axi_rvalid && ar_last_reg == addr_partner_ability |-> !s_axi_rdata[12])
      else $error("reserved ability bit set");
   chk_ack_view: assert property (engine_in.local_ack |-> ##[1:2] page_out[14])
      else $error("acknowledge not shown");
   chk_ack_clear: assert property (!engine_in.local_ack [*3] |-> !page_out[14])
      else $error("acknowledge shown without cause");
   chk_toggle_cause: assert property ($changed(page_out[11]) |-> $past(engine_in.word_sent) || $past(engine_in.word_sent, 2))
      else $error("toggle changed without a sent word");
   chk_page_reset: assert property ($rose(aresetn) |-> page_out == 16'h2801)
      else $error("outgoing page reset value wrong");
   cov_exp_read: cover property (s_axi_rvalid && ar_last_reg == addr_negotiation_expansion);
   cov_word_sent: cover property (engine_in.word_sent);
   cov_write: cover property (s_axi_bvalid);
endmodule
`default_nettype wire

// file: sim/engine_model.sv
// Negotiation engine stand-in feeding received pages and link levels
`timescale 1ns/10ps
`default_nettype none
module engine_model
   import an_regs_pkg::*;
(
   // Clock
   input wire logic aclk,
   // Bench commands
   input wire logic send,
   input wire logic nsend,
   input wire logic [15:0] word,
   input wire logic [3:0] lvl,
   input wire logic sent,
   // Toward the block
   output var engine_in_type engine_in
);
   initial engine_in = '0;
   // Page lines outside a page strobe invert every cycle, so the last word shows again every second cycle
   always @(posedge aclk) begin
      engine_in.base_page_valid <= send;
      engine_in.base_page <= send ? word : ~engine_in.base_page;
      engine_in.next_page_valid <= nsend;
      engine_in.next_page <= nsend ? word : ~engine_in.next_page;
      engine_in.page_received <= send;
      engine_in.partner_negotiates <= lvl[0];
      engine_in.partner_multi_page <= lvl[1];
      engine_in.parallel_detect_fault <= lvl[2];
      engine_in.local_ack <= lvl[3];
      engine_in.word_sent <= sent;
   end
endmodule
`default_nettype wire

// file: sim/testbench.sv
// Self-checking bench for the partner page register bank
`timescale 1ns/10ps
`default_nettype none
module testbench
   import an_regs_pkg::*;
();
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, send = 0, sent = 0;
   logic nsend = 0;
   logic [15:0] ab = 0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [7:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata;
   logic [1:0] bresp, rresp;
   logic [15:0] word = 0, seed = 16'h005C, page_out;
   logic [3:0] lvl = 0;
   logic [33:0] r;
   engine_in_type engine_in;
   int n_errors = 0, tests_run = 0, cycles = 0;
   autoneg_partner_page_regs u_dut(.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .engine_in(engine_in), .page_out(page_out), .engine_enable());
   engine_model u_far(.aclk(aclk), .send(send), .nsend(nsend), .word(word), .lvl(lvl), .sent(sent),
      .engine_in(engine_in));
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic [33:0] exp_exp(input logic [3:0] l, input logic rx);
      return {resp_okay, 25'h0, 2'b11, l[2], l[1], 1'b1, rx, l[0]};
   endfunction
   function automatic logic [33:0] exp_out(input logic [15:0] w, input logic tog, input logic ack);
      return {resp_okay, 16'h0, (w & 16'hB7FF) | {1'b0, ack, 2'h0, ~tog, 11'h0}};
   endfunction
   task automatic check(input logic [33:0] got, input logic [33:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid);
      r = {rresp, rdata};
      rready <= 1'b0;
   endtask
   task automatic pulse_page(input logic [15:0] w, input logic [3:0] l, input logic nx);
      @(posedge aclk);
      word <= w;
      lvl <= l;
      send <= !nx;
      nsend <= nx;
      @(posedge aclk);
      send <= 1'b0;
      nsend <= 1'b0;
      repeat (3) @(posedge aclk);
   endtask
   task automatic tally_and_finish;
      $display("tests %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial forever #5 aclk = ~aclk;
   // Cuts a hung handshake short
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 5000) begin
         n_errors++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      rd(addr_partner_ability); check(r, {resp_okay, 32'h0});
      rd(addr_negotiation_expansion); check(r, exp_exp(4'h0, 1'b0));
      rd(addr_outgoing_page); check(r, exp_out(16'h2001, 1'b0, 1'b0));
      $display("done: reset values");
      for (int i = 0; i < 6; i++) begin
         seed = lfsr(seed);
         pulse_page((i == 0) ? 16'hFFFF : seed, seed[3:0], 1'b0);
         ab = word & 16'hEFFF;
         rd(addr_partner_ability); check(r, {resp_okay, 16'h0, ab});
         rd(addr_negotiation_expansion); check(r, exp_exp(lvl, 1'b1));
         rd(addr_negotiation_expansion); check(r, exp_exp(lvl, 1'b0));
         // A later page lands only when the partner does next pages
         pulse_page(~word, lvl, 1'b1);
         if (lvl[1]) ab = word & 16'hEFFF;
         rd(addr_partner_ability); check(r, {resp_okay, 16'h0, ab});
      end
      $display("done: received pages");
      wr(addr_partner_ability, 32'hFFFF_FFFF);
      rd(addr_partner_ability); check(r, {resp_okay, 16'h0, ab});
      wr(addr_negotiation_expansion, 32'hFFFF_FFFF);
      rd(addr_negotiation_expansion); check(r, exp_exp(lvl, 1'b0));
      wr(addr_outgoing_page, 32'hFFFF_FFFF);
      rd(addr_outgoing_page); check(r, exp_out(16'hFFFF, 1'b0, lvl[3]));
      @(posedge aclk);
      sent <= 1'b1;
      @(posedge aclk);
      sent <= 1'b0;
      rd(addr_outgoing_page); check(r, exp_out(16'hFFFF, 1'b1, lvl[3]));
      wr(addr_outgoing_page, 32'h0);
      rd(addr_outgoing_page); check(r, exp_out(16'h0, 1'b1, lvl[3]));
      check({18'h0, page_out}, exp_out(16'h0, 1'b1, lvl[3]));
      $display("done: outgoing page");
      rd(8'h30); check(r, {resp_slverr, bad_addr_data});
      $display("done: unmapped read");
      tally_and_finish();
   end
endmodule
bind autoneg_partner_page_regs an_regs_monitor u_mon(.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .engine_in(engine_in), .page_out(page_out));
`default_nettype wire
